// [design/bfs_consts.svh]
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and time conversion
// ----------------------------------------------------------------------
`define BFS_CLK_MHZ 125
`define BFS_US(t) ((t) * `BFS_CLK_MHZ)
`define BFS_MS(t) ((t) * `BFS_CLK_MHZ * 1000)
`define BFS_NS(t) (((t) * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_S(t) (64'(t) * 64'(`BFS_CLK_MHZ) * 64'd1000000)

// ----------------------------------------------------------------------
// Minimum durations and delays, in their printed units, and the undervoltage restart limit
// ----------------------------------------------------------------------
`define BFS_T_FIL_US 100
`define BFS_T_LS32_US 620
`define BFS_T_PU_WIN_US 10
`define BFS_T_UV12_US 1
`define BFS_T_OV105_US 5
`define BFS_T_OV109_US 5
`define BFS_T_UV75_US 84
`define BFS_T_UVDLY_US 120
`define BFS_T_START_MS 80
`define BFS_T_AUTO_MS 200
`define BFS_T_UVRST_MS 100
`define BFS_T_INVOV_MS 625
`define BFS_T_PEAK_US 620
`define BFS_T_RECT_MS 2500
`define BFS_T_CAP_US 620
`define BFS_T_IGN_MS 237
`define BFS_T_FRST_MS 200
`define BFS_T_PFC_NS 200
`define BFS_T_ICL_NS 200
`define BFS_T_IGNCS_NS 500
`define BFS_T_CLR_S 40
`define BFS_UV_MAX 7

// ----------------------------------------------------------------------
// Sizes and filter slots
// ----------------------------------------------------------------------
`define BFS_NF 16
`define BFS_CW 32
`define BFS_RW 36
`define BFS_F_HS 0
`define BFS_F_LS16 1
`define BFS_F_LS32 2
`define BFS_F_UV12 3
`define BFS_F_OV105 4
`define BFS_F_OV109 5
`define BFS_F_UV75 6
`define BFS_F_START 7
`define BFS_F_INVOV 8
`define BFS_F_PEAK 9
`define BFS_F_RECT 10
`define BFS_F_CAP 11
`define BFS_F_IGN 12
`define BFS_F_PFC 13
`define BFS_F_ICL 14
`define BFS_F_IGNCS 15

`endif

// [design/bfs_pkg.sv]
package bfs_pkg;
`include "bfs_consts.svh"

   typedef enum logic [2:0] {PH_MONITOR, PH_POWER_UP, PH_STARTUP, PH_SOFTSTART,
      PH_PREHEAT, PH_IGNITION, PH_PRERUN, PH_RUN} bfs_phase_t;

   typedef enum logic [2:0] {RS_IDLE, RS_HOLD, RS_UV_DELAY, RS_WAIT_TIME, RS_WAIT_BUS,
      RS_LATCHED} bfs_react_t;

   typedef struct packed {
      logic supply_undervoltage_lockout;
      logic lamp_sense_b_low;
      logic lowside_filament_sense_16;
      logic lowside_filament_sense_32;
      logic bus_lt_12;
      logic bus_lt_75;
      logic bus_ge_95;
      logic bus_gt_105;
      logic bus_gt_109;
      logic lamp_peak_overvoltage;
      logic lamp_rectifier_effect;
      logic cap_load;
      logic pfc_current_sense;
      logic inverter_current_sense;
   } bfs_cmp_t;

   typedef struct packed {
      logic power_down;
      logic power_up_block;
      logic pfc_stop;
      logic pfc_on_end;
      logic inv_cur_limit;
      logic ign_ctrl;
      logic restart;
      logic skip_preheat;
      logic latched_fault;
   } bfs_out_t;

   typedef struct packed {
      bfs_cmp_t s1;
      bfs_cmp_t s2;
      bfs_cmp_t s3;
      bfs_cmp_t cmp;
      bfs_phase_t ph_prev;
      logic [15:0] ph_age;
      logic [`BFS_NF-1:0][`BFS_CW-1:0] cnt;
      bfs_react_t rs;
      logic [`BFS_CW-1:0] tmr;
      logic [`BFS_RW-1:0] run_tmr;
      logic f_used;
      logic [2:0] uv_cnt;
      bfs_out_t o;
   } bfs_state_t;

   // Minimum durations and delays in clock cycles, handed over as one set.
   typedef struct packed {
      logic [31:0] fil;
      logic [31:0] ls32;
      logic [31:0] uv75;
      logic [31:0] uvdly;
      logic [31:0] start;
      logic [31:0] auto_rst;
      logic [31:0] uvrst;
      logic [31:0] invov;
      logic [31:0] peak;
      logic [31:0] rect;
      logic [31:0] cap;
      logic [31:0] ign;
      logic [31:0] frst;
      logic [63:0] clr;
   } bfs_cyc_t;

endpackage : bfs_pkg

// [design/bfs_supervisor.sv]
`timescale 1ns/1ns
`include "bfs_consts.svh"
module bfs_supervisor #(
   parameter bfs_pkg::bfs_cyc_t CYC = '{fil: 32'(`BFS_US(`BFS_T_FIL_US)),
      ls32: 32'(`BFS_US(`BFS_T_LS32_US)), uv75: 32'(`BFS_US(`BFS_T_UV75_US)),
      uvdly: 32'(`BFS_US(`BFS_T_UVDLY_US)), start: 32'(`BFS_MS(`BFS_T_START_MS)),
      auto_rst: 32'(`BFS_MS(`BFS_T_AUTO_MS)), uvrst: 32'(`BFS_MS(`BFS_T_UVRST_MS)),
      invov: 32'(`BFS_MS(`BFS_T_INVOV_MS)), peak: 32'(`BFS_US(`BFS_T_PEAK_US)),
      rect: 32'(`BFS_MS(`BFS_T_RECT_MS)), cap: 32'(`BFS_US(`BFS_T_CAP_US)),
      ign: 32'(`BFS_MS(`BFS_T_IGN_MS)), frst: 32'(`BFS_MS(`BFS_T_FRST_MS)),
      clr: 64'(`BFS_S(`BFS_T_CLR_S))}
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire bfs_pkg::bfs_cmp_t cmp_pins,
   input wire bfs_pkg::bfs_phase_t phase,
   input wire logic run_freq_reached,
   output bfs_pkg::bfs_out_t outs
);

   // ----------------------------------------------------------------------
   // Thresholds
   // ----------------------------------------------------------------------
   localparam int unsigned FIL_CYC = CYC.fil;
   localparam int unsigned LS32_CYC = CYC.ls32;
   localparam int unsigned UV75_CYC = CYC.uv75;
   localparam int unsigned UVDLY_CYC = CYC.uvdly;
   localparam int unsigned START_CYC = CYC.start;
   localparam int unsigned AUTO_CYC = CYC.auto_rst;
   localparam int unsigned UVRST_CYC = CYC.uvrst;
   localparam int unsigned INVOV_CYC = CYC.invov;
   localparam int unsigned PEAK_CYC = CYC.peak;
   localparam int unsigned RECT_CYC = CYC.rect;
   localparam int unsigned CAP_CYC = CYC.cap;
   localparam int unsigned IGN_CYC = CYC.ign;
   localparam int unsigned FRST_CYC = CYC.frst;
   localparam longint unsigned CLR_CYC = CYC.clr;
   localparam int unsigned PU_WIN_CYC = `BFS_US(`BFS_T_PU_WIN_US);
   localparam logic [`BFS_CW-1:0] THR [`BFS_NF] = '{
      FIL_CYC, FIL_CYC, LS32_CYC, `BFS_US(`BFS_T_UV12_US), `BFS_US(`BFS_T_OV105_US),
      `BFS_US(`BFS_T_OV109_US), UV75_CYC, START_CYC, INVOV_CYC, PEAK_CYC, RECT_CYC,
      CAP_CYC, IGN_CYC, `BFS_NS(`BFS_T_PFC_NS), `BFS_NS(`BFS_T_ICL_NS),
      `BFS_NS(`BFS_T_IGNCS_NS)};

   // Counters are 32 bits and the run timer 36 bits; zero would qualify at once, with no condition.
   if (FIL_CYC == 0 || LS32_CYC == 0 || UV75_CYC == 0 || UVDLY_CYC == 0 ||
      START_CYC == 0 || AUTO_CYC == 0 || UVRST_CYC == 0 || INVOV_CYC == 0 ||
      PEAK_CYC == 0 || RECT_CYC == 0 || CAP_CYC == 0 || IGN_CYC == 0 ||
      FRST_CYC == 0 || CLR_CYC == 0 || CLR_CYC >= 64'h0000_0010_0000_0000)
   begin : g_bad_count
      $error("bfs_supervisor: every cycle count must be non-zero and fit its counter");
   end

   function automatic logic [`BFS_CW-1:0] qual_step(input logic [`BFS_CW-1:0] cnt,
      input logic cond, input logic [`BFS_CW-1:0] thr);
      if (!cond)
      begin
         return '0;
      end
      return (cnt == thr) ? cnt : cnt + 32'h1;
   endfunction : qual_step

   bfs_pkg::bfs_state_t st_r;
   bfs_pkg::bfs_state_t st_nxt;
   bfs_pkg::bfs_cmp_t c;
   logic idle;
   logic active;
   logic run;
   logic pu_win;
   logic f_evt;
   logic [`BFS_NF-1:0] cond;
   logic [`BFS_NF-1:0] q;

   assign outs = st_r.o;

   // ----------------------------------------------------------------------
   // Detection conditions per operating phase
   // ----------------------------------------------------------------------
   assign c = st_r.cmp;
   assign idle = st_r.rs == bfs_pkg::RS_IDLE;
   assign active = idle && phase != bfs_pkg::PH_MONITOR && phase != bfs_pkg::PH_POWER_UP;
   assign run = idle && phase == bfs_pkg::PH_RUN;
   assign pu_win = idle && phase == bfs_pkg::PH_POWER_UP && st_r.ph_age >= 16'(PU_WIN_CYC);

   assign cond[`BFS_F_HS] = idle && phase == bfs_pkg::PH_MONITOR && c.lamp_sense_b_low;
   assign cond[`BFS_F_LS16] = idle && phase == bfs_pkg::PH_MONITOR &&
      c.lowside_filament_sense_16;
   assign cond[`BFS_F_LS32] = run && c.lowside_filament_sense_32;
   assign cond[`BFS_F_UV12] = pu_win && c.bus_lt_12;
   assign cond[`BFS_F_OV105] = pu_win && c.bus_gt_105;
   assign cond[`BFS_F_OV109] = active && c.bus_gt_109;
   assign cond[`BFS_F_UV75] = run && c.bus_lt_75;
   assign cond[`BFS_F_START] = idle && phase == bfs_pkg::PH_STARTUP && !c.bus_ge_95;
   assign cond[`BFS_F_INVOV] = run && c.bus_gt_109;
   assign cond[`BFS_F_PEAK] = run && c.lamp_peak_overvoltage;
   assign cond[`BFS_F_RECT] = run && c.lamp_rectifier_effect;
   assign cond[`BFS_F_CAP] = run && c.cap_load;
   assign cond[`BFS_F_IGN] = idle && phase == bfs_pkg::PH_IGNITION && !run_freq_reached;
   assign cond[`BFS_F_PFC] = active && c.pfc_current_sense;
   assign cond[`BFS_F_ICL] = active && c.inverter_current_sense;
   assign cond[`BFS_F_IGNCS] = idle && phase == bfs_pkg::PH_IGNITION &&
      c.inverter_current_sense;

   // A slot is qualified once its counter has reached the minimum duration.
   for (genvar i = 0; i < `BFS_NF; i++)
   begin : g_qual
      assign q[i] = st_r.cnt[i] == THR[i];
   end

   assign f_evt = q[`BFS_F_LS32] || q[`BFS_F_PEAK] || q[`BFS_F_RECT] || q[`BFS_F_CAP] ||
      q[`BFS_F_IGN] || q[`BFS_F_IGNCS];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      // Pins are asynchronous; a level counts only once stages two and three agree.
      st_nxt.s1 = cmp_pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.cmp = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.cmp);

      st_nxt.ph_prev = phase;
      if (phase != st_r.ph_prev)
      begin
         st_nxt.ph_age = '0;
      end
      else if (st_r.ph_age != 16'hFFFF)
      begin
         st_nxt.ph_age = st_r.ph_age + 16'h1;
      end

      for (int i = 0; i < `BFS_NF; i++)
      begin
         st_nxt.cnt[i] = qual_step(st_r.cnt[i], cond[i], THR[i]);
      end

      st_nxt.o.restart = 1'b0;
      case (st_r.rs)
         bfs_pkg::RS_IDLE:
         begin
            if (f_evt)
            begin
               if (st_r.f_used)
               begin
                  st_nxt.rs = bfs_pkg::RS_LATCHED;
               end
               else
               begin
                  st_nxt.f_used = 1'b1;
                  st_nxt.rs = bfs_pkg::RS_WAIT_TIME;
                  st_nxt.tmr = FRST_CYC - 32'h1;
                  st_nxt.o.skip_preheat = 1'b0;
               end
            end
            else if (q[`BFS_F_UV12] || q[`BFS_F_OV105])
            begin
               st_nxt.rs = bfs_pkg::RS_HOLD;
            end
            else if (q[`BFS_F_INVOV])
            begin
               st_nxt.rs = bfs_pkg::RS_WAIT_BUS;
            end
            else if (q[`BFS_F_START])
            begin
               st_nxt.rs = bfs_pkg::RS_WAIT_TIME;
               st_nxt.tmr = AUTO_CYC - 32'h1;
               st_nxt.o.skip_preheat = 1'b0;
            end
            else if (q[`BFS_F_UV75])
            begin
               st_nxt.rs = bfs_pkg::RS_UV_DELAY;
               st_nxt.tmr = UVDLY_CYC - 32'h1;
            end
         end
         bfs_pkg::RS_UV_DELAY:
         begin
            if (st_r.tmr != '0)
            begin
               st_nxt.tmr = st_r.tmr - 32'h1;
            end
            else if (st_r.uv_cnt == 3'(`BFS_UV_MAX))
            begin
               // Restart budget spent: stay down until the supply cycles.
               st_nxt.rs = bfs_pkg::RS_HOLD;
            end
            else
            begin
               st_nxt.uv_cnt = st_r.uv_cnt + 3'h1;
               st_nxt.rs = bfs_pkg::RS_WAIT_TIME;
               st_nxt.tmr = UVRST_CYC - 32'h1;
               st_nxt.o.skip_preheat = 1'b1;
            end
         end
         bfs_pkg::RS_WAIT_TIME:
         begin
            if (st_r.tmr == '0)
            begin
               st_nxt.rs = bfs_pkg::RS_IDLE;
               st_nxt.o.restart = 1'b1;
            end
            else
            begin
               st_nxt.tmr = st_r.tmr - 32'h1;
            end
         end
         bfs_pkg::RS_WAIT_BUS:
         begin
            if (!c.bus_gt_105)
            begin
               st_nxt.rs = bfs_pkg::RS_IDLE;
               st_nxt.o.restart = 1'b1;
            end
         end
         bfs_pkg::RS_HOLD, bfs_pkg::RS_LATCHED:
         begin
            st_nxt.rs = st_r.rs;
         end
         default:
         begin
            st_nxt.rs = bfs_pkg::RS_IDLE;
         end
      endcase

      // Continuous run time clears the single-restart memory.
      if (run)
      begin
         if (st_r.run_tmr == 36'(CLR_CYC - 64'h1))
         begin
            // A fault caught in the same cycle keeps its mark; the set wins.
            if (!f_evt)
            begin
               st_nxt.f_used = 1'b0;
            end
         end
         else
         begin
            st_nxt.run_tmr = st_r.run_tmr + 36'h1;
         end
      end
      else
      begin
         st_nxt.run_tmr = '0;
      end

      // Supply lockout overrides the reaction state and clears the restart memory, restart and skip-preheat.
      if (c.supply_undervoltage_lockout)
      begin
         st_nxt.rs = bfs_pkg::RS_IDLE;
         st_nxt.f_used = 1'b0;
         st_nxt.uv_cnt = '0;
         st_nxt.o.skip_preheat = 1'b0;
         st_nxt.o.restart = 1'b0;
      end

      // The PFC stop is set before it is cleared, so a new trip is never lost.
      if (q[`BFS_F_OV109])
      begin
         st_nxt.o.pfc_stop = 1'b1;
      end
      else if (!c.bus_gt_105 || !active)
      begin
         st_nxt.o.pfc_stop = 1'b0;
      end

      st_nxt.o.power_down = st_nxt.rs != bfs_pkg::RS_IDLE &&
         st_nxt.rs != bfs_pkg::RS_UV_DELAY;
      st_nxt.o.power_up_block = q[`BFS_F_HS] || q[`BFS_F_LS16];
      st_nxt.o.pfc_on_end = q[`BFS_F_PFC];
      st_nxt.o.inv_cur_limit = q[`BFS_F_ICL];
      st_nxt.o.ign_ctrl = q[`BFS_F_IGNCS];
      st_nxt.o.latched_fault = st_nxt.rs == bfs_pkg::RS_LATCHED;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   sequence s_first_fault;
      idle && f_evt && !st_r.f_used && !c.supply_undervoltage_lockout;
   endsequence

   sequence s_uv_enter;
      idle && !f_evt && !q[`BFS_F_UV12] && !q[`BFS_F_OV105] && !q[`BFS_F_INVOV] &&
         !q[`BFS_F_START] && q[`BFS_F_UV75] && !c.supply_undervoltage_lockout;
   endsequence

   a_qual_clear: assert property (!cond[`BFS_F_PEAK] |=> st_r.cnt[`BFS_F_PEAK] == '0)
      else $error("peak filter counter did not clear");
   a_pu_block: assert property ((q[`BFS_F_HS] || q[`BFS_F_LS16]) |=> outs.power_up_block)
      else $error("open filament did not block power-up");
   a_first_fault: assert property (s_first_fault |=> (outs.power_down && !outs.restart &&
      !outs.latched_fault)[*8])
      else $error("first single-restart fault handled wrongly");
   a_second_fault: assert property (idle && f_evt && st_r.f_used &&
      !c.supply_undervoltage_lockout |=> outs.latched_fault)
      else $error("second single-restart fault did not latch");
   a_uv_delay: assert property (s_uv_enter |=> (!outs.power_down)[*8])
      else $error("undervoltage shutdown not delayed");
   a_uv_limit: assert property (st_r.rs == bfs_pkg::RS_UV_DELAY && st_r.tmr == '0 &&
      st_r.uv_cnt == 3'(`BFS_UV_MAX) && !c.supply_undervoltage_lockout |=>
      st_r.rs == bfs_pkg::RS_HOLD && outs.power_down)
      else $error("more undervoltage restarts than allowed");
   a_hold_gates: assert property (st_r.rs == bfs_pkg::RS_HOLD &&
      !c.supply_undervoltage_lockout |=> outs.power_down && !outs.restart)
      else $error("gate drives not kept off");
   a_latch_clear: assert property (c.supply_undervoltage_lockout |=>
      !outs.latched_fault && !st_r.f_used)
      else $error("lockout did not clear the failure latch");
   a_pfc_stop: assert property (q[`BFS_F_OV109] |=> outs.pfc_stop)
      else $error("PFC overvoltage did not stop the switch");
   a_bus_wait: assert property (st_r.rs == bfs_pkg::RS_WAIT_BUS && c.bus_gt_105 &&
      !c.supply_undervoltage_lockout |=> outs.power_down && !outs.restart)
      else $error("restarted while bus still high");
   a_fast_limit: assert property (q[`BFS_F_PFC] && q[`BFS_F_ICL] |=>
      outs.pfc_on_end && outs.inv_cur_limit)
      else $error("current limits not applied");
   a_restart_pulse: assert property ($rose(outs.restart) |=> !outs.restart)
      else $error("restart longer than one cycle");

endmodule : bfs_supervisor

// [testbench/bfs_analog_model.sv]
`timescale 1ns/1ns
module bfs_analog_model (
   input wire logic core_clk,
   output bfs_pkg::bfs_cmp_t cmp_pins,
   output bfs_pkg::bfs_phase_t phase,
   output logic run_freq_reached
);
   // Comparator levels and sequencer phase stand still between calls, as a real front end
   // would hold a settled level; every change lands just after a rising edge.
   initial
   begin
      cmp_pins = '0;
      phase = bfs_pkg::PH_MONITOR;
      run_freq_reached = 1'b0;
   end

   task automatic drive(input bfs_pkg::bfs_cmp_t c, input bfs_pkg::bfs_phase_t p,
      input logic rf);
      @(posedge core_clk);
      cmp_pins <= c;
      phase <= p;
      run_freq_reached <= rf;
   endtask : drive
endmodule : bfs_analog_model

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   localparam int PD = 8, PUB = 7, PST = 6, POE = 5, ICL = 4, IGC = 3, RST = 2, SKP = 1;
   localparam int LAT = 0;
   localparam logic [13:0] SUPPLY_UNDERVOLTAGE_LOCKOUT = 14'h2000, LSB = 14'h1000, LS16 = 14'h0800;
   localparam logic [13:0] LS32 = 14'h0400, LT12 = 14'h0200, LT75 = 14'h0100;
   localparam logic [13:0] GE95 = 14'h0080, GT105 = 14'h0040, GT109 = 14'h0020;
   localparam logic [13:0] PEAK = 14'h0010;
   // Shortened durations so that every timer expires within a short run.
   localparam bfs_pkg::bfs_cyc_t SHORT_CYC = '{fil: 32'h14, ls32: 32'h1E, uv75: 32'h14,
      uvdly: 32'h14, start: 32'h32, auto_rst: 32'h28, uvrst: 32'h28, invov: 32'h3C,
      peak: 32'h1E, rect: 32'h46, cap: 32'h1E, ign: 32'h32, frst: 32'h28, clr: 64'h64};
   localparam logic [13:0] RECT = 14'h0008, CAP = 14'h0004, PFC = 14'h0002, INV = 14'h0001;
   logic core_clk;
   logic srst;
   bfs_pkg::bfs_cmp_t cmp_pins;
   bfs_pkg::bfs_phase_t phase;
   logic run_freq_reached;
   bfs_pkg::bfs_out_t outs;
   int fail_count;
   int n_tests;
   int cyc;

   bfs_supervisor #(.CYC(SHORT_CYC))
   i_bfs_supervisor (.core_clk(core_clk), .srst(srst), .cmp_pins(cmp_pins), .phase(phase),
      .run_freq_reached(run_freq_reached), .outs(outs));

   bfs_analog_model i_bfs_analog_model (.core_clk(core_clk), .cmp_pins(cmp_pins),
      .phase(phase), .run_freq_reached(run_freq_reached));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic results;
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic drv(input logic [13:0] c, input bfs_pkg::bfs_phase_t p, input logic rf);
      i_bfs_analog_model.drive(bfs_pkg::bfs_cmp_t'(c), p, rf);
   endtask : drv

   // An output that settles before lo cycles is as wrong as one that never comes.
   task automatic wait_bit(input int b, input logic v, input int lo, input int hi);
      logic early;
      int n;
      early = 1'b0;
      n = 0;
      repeat (lo)
      begin
         tick(1);
         if (outs[b] === v)
            early = 1'b1;
      end
      while (outs[b] !== v && n < hi - lo)
      begin
         tick(1);
         n++;
      end
      check({7'h00, early, outs[b]}, {7'h00, 1'b0, v});
   endtask : wait_bit

   task automatic do_reset;
      drv(14'h0000, bfs_pkg::PH_MONITOR, 1'b0);
      srst <= 1'b1;
      tick(4);
      @(posedge core_clk);
      srst <= 1'b0;
      tick(8);
   endtask : do_reset

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_filament(input logic [13:0] p);
      do_reset();
      drv(p, bfs_pkg::PH_MONITOR, 1'b0);
      tick(12);
      drv(14'h0000, bfs_pkg::PH_MONITOR, 1'b0);
      tick(3);
      drv(p, bfs_pkg::PH_MONITOR, 1'b0);
      wait_bit(PUB, 1'b1, 20, 35);
      drv(14'h0000, bfs_pkg::PH_MONITOR, 1'b0);
      wait_bit(PUB, 1'b0, 0, 10);
   endtask : t_filament

   task automatic t_fault(input logic [13:0] p, input int thr, input bfs_pkg::bfs_phase_t ph,
      input logic rf);
      do_reset();
      drv(p, ph, rf);
      wait_bit(PD, 1'b1, thr, thr + 15);
      check({8'h00, outs[LAT]}, 9'h000);
      drv(14'h0000, ph, rf);
      wait_bit(RST, 1'b1, 30, 50);
      check({6'h00, outs[PD], outs[LAT], outs[SKP]}, 9'h000);
      drv(p, ph, rf);
      wait_bit(LAT, 1'b1, thr - 5, thr + 15);
      drv(SUPPLY_UNDERVOLTAGE_LOCKOUT, ph, rf);
      wait_bit(LAT, 1'b0, 0, 10);
   endtask : t_fault

   task automatic t_clear;
      do_reset();
      drv(PEAK, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(PD, 1'b1, 30, 45);
      drv(14'h0000, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(RST, 1'b1, 30, 50);
      tick(150);
      drv(PEAK, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(PD, 1'b1, 25, 45);
      check({8'h00, outs[LAT]}, 9'h000);
   endtask : t_clear

   task automatic t_limit;
      do_reset();
      drv(PFC | INV, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(POE, 1'b1, 20, 35);
      check({6'h00, outs[ICL], outs[PD], outs[LAT]}, 9'h004);
      drv(14'h0000, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(POE, 1'b0, 0, 10);
      wait_bit(ICL, 1'b0, 0, 10);
      drv(INV, bfs_pkg::PH_IGNITION, 1'b1);
      wait_bit(IGC, 1'b1, 55, 80);
   endtask : t_limit

   task automatic t_overvolt;
      do_reset();
      drv(GT105 | GT109, bfs_pkg::PH_PRERUN, 1'b1);
      wait_bit(PST, 1'b1, 620, 650);
      drv(GT105, bfs_pkg::PH_PRERUN, 1'b1);
      tick(20);
      check({8'h00, outs[PST]}, 9'h001);
      drv(14'h0000, bfs_pkg::PH_PRERUN, 1'b1);
      wait_bit(PST, 1'b0, 0, 10);
      drv(GT105 | GT109, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(PD, 1'b1, 55, 75);
      drv(GT105, bfs_pkg::PH_RUN, 1'b1);
      tick(20);
      check({8'h00, outs[PD]}, 9'h001);
      drv(14'h0000, bfs_pkg::PH_RUN, 1'b1);
      wait_bit(RST, 1'b1, 0, 12);
   endtask : t_overvolt

   task automatic t_undervolt;
      do_reset();
      drv(LT75, bfs_pkg::PH_RUN, 1'b1);
      for (int i = 0; i < 7; i++)
      begin
         wait_bit(PD, 1'b1, 35, 60);
         check({8'h00, outs[SKP]}, 9'h001);
         wait_bit(RST, 1'b1, 30, 50);
      end
      wait_bit(PD, 1'b1, 35, 60);
      tick(60);
      check({8'h00, outs[PD]}, 9'h001);
   endtask : t_undervolt

   task automatic t_powerup(input logic [13:0] p, input int thr);
      do_reset();
      drv(p, bfs_pkg::PH_POWER_UP, 1'b0);
      wait_bit(PD, 1'b1, thr - 10, thr + 20);
      tick(50);
      check({8'h00, outs[PD]}, 9'h001);
      drv(SUPPLY_UNDERVOLTAGE_LOCKOUT, bfs_pkg::PH_POWER_UP, 1'b0);
      wait_bit(PD, 1'b0, 0, 10);
   endtask : t_powerup

   // The start-up timer must restart from zero once the bus has reached 95%.
   task automatic t_startup;
      do_reset();
      drv(14'h0000, bfs_pkg::PH_STARTUP, 1'b0);
      tick(30);
      drv(GE95, bfs_pkg::PH_STARTUP, 1'b0);
      tick(10);
      drv(14'h0000, bfs_pkg::PH_STARTUP, 1'b0);
      wait_bit(PD, 1'b1, 45, 65);
      wait_bit(RST, 1'b1, 30, 50);
   endtask : t_startup

   // ----------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fail_count++;
         results();
      end
   end

   initial
   begin
      srst = 1'b1;
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      t_filament(LSB);
      t_filament(LS16);
      t_fault(LS32, 30, bfs_pkg::PH_RUN, 1'b1);
      t_fault(PEAK, 30, bfs_pkg::PH_RUN, 1'b1);
      t_fault(RECT, 70, bfs_pkg::PH_RUN, 1'b1);
      t_fault(CAP, 30, bfs_pkg::PH_RUN, 1'b1);
      t_fault(14'h0000, 50, bfs_pkg::PH_IGNITION, 1'b0);
      t_fault(INV, 63, bfs_pkg::PH_IGNITION, 1'b1);
      t_clear();
      t_limit();
      t_overvolt();
      t_undervolt();
      t_startup();
      t_powerup(LT12, 1375);
      t_powerup(GT105, 1875);
      results();
   end
endmodule : tb_top
